// >>> hw/sds_pkg.sv
// Purpose: Constants and types for the synthesizer divider, resync and
//          power register bank.
// Assumes: Eight-bit registers reached over the serial register port.
// Notes:   The SPI frame is a 16-bit command (read flag, 15-bit address)
//          followed by one data byte.
// How it works
// - Retime edge bit picks rising (0) or falling (1) detector clock edge.
// - Polarity code 00 never inverts the reference divider output, 01 always.
// - Code 10 keeps high duty 50-67%, code 11 keeps 33-50%.
// - Select bit picks shared (0) or dedicated (1) feedback divider field.
// - Dedicated feedback code divides by 1, 2, 4 or 8, used when selected.
// - Shared code always sets reference divider, and feedback when unselected.
// - Low and high bytes form the 16-bit resync wait count.
// - Reset selector bit chooses which event starts the resync wait.
// - Dither position field and the two accumulator dither enables.
// - Auxiliary modulator enable and add-one-to-LSB enable.
// - Amplitude register holds output B code high, output A code low.
// - Reference detector power down bit resets to one.
// - Sync and temperature ADC power down bits reset to zero.
// - All registers reset to zero except power control at 0x2a, which resets to 0x04.
// - Resync wait and selector act only while resync mode is enabled.
package sds_pkg;

	localparam logic [14:0] ADDR_REF_CTRL = 15'h0024;
	localparam logic [14:0] ADDR_WAIT_LO  = 15'h0025;
	localparam logic [14:0] ADDR_WAIT_HI  = 15'h0026;
	localparam logic [14:0] ADDR_SPARE    = 15'h0027;
	localparam logic [14:0] ADDR_MOD_CTRL = 15'h0028;
	localparam logic [14:0] ADDR_AMP      = 15'h0029;
	localparam logic [14:0] ADDR_AUX_PD   = 15'h002a;

	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_AUX_PD = 8'h04;

	localparam int B_EDGE    = 7;
	localparam int B_POL_HI  = 6;
	localparam int B_POL_LO  = 5;
	localparam int B_FB_SEL  = 4;
	localparam int B_FB_HI   = 3;
	localparam int B_FB_LO   = 2;
	localparam int B_SH_HI   = 1;
	localparam int B_SH_LO   = 0;
	localparam int B_RS_SEL  = 7;
	localparam int B_MODULATOR_LSB_PLUS_ONE  = 6;
	localparam int B_AUX_MOD = 5;
	localparam int B_DIT_HI  = 4;
	localparam int B_DIT_LO  = 2;
	localparam int B_DIT2    = 1;
	localparam int B_DIT1    = 0;
	localparam int B_AMPB_HI = 7;
	localparam int B_AMPB_LO = 4;
	localparam int B_AMPA_HI = 3;
	localparam int B_AMPA_LO = 0;
	localparam int B_SYNC_POWER_DOWN = 4;
	localparam int B_REF_DETECTOR_POWER_DOWN = 2;
	localparam int B_TEMP_ADC_POWER_DOWN  = 1;

	localparam logic [1:0] POL_NEVER   = 2'h0;
	localparam logic [1:0] POL_ALWAYS  = 2'h1;
	localparam logic [1:0] POL_HI_DUTY = 2'h2;
	localparam logic [1:0] POL_LO_DUTY = 2'h3;

	localparam logic [4:0] LAST_CMD_BIT  = 5'h0f;
	localparam logic [4:0] LAST_DATA_BIT = 5'h17;
	localparam int         B_RD_FLAG     = 15;

	typedef enum logic [1:0] {
		SDS_IDLE = 2'b00,
		SDS_CMD  = 2'b01,
		SDS_DATA = 2'b10,
		SDS_DONE = 2'b11
	} sds_spi_st_t;

	typedef struct packed {
		logic [7:0] ref_ctrl;
		logic [7:0] wait_lo;
		logic [7:0] wait_hi;
		logic [7:0] spare;
		logic [7:0] mod_ctrl;
		logic [7:0] amp;
		logic [7:0] aux_pd;
	} sds_regs_t;

	typedef struct packed {
		logic        ref_retime_edge_sel;
		logic        ref_invert;
		logic [3:0]  ref_div1_ratio;
		logic [3:0]  fb_div1_ratio;
		logic [15:0] resync_wait;
		logic        resync_reset_select;
		logic        modulator_lsb_plus_one;
		logic        aux_mod_enable;
		logic [2:0]  first_dither_position;
		logic        second_acc_dither_enable;
		logic        first_acc_dither_enable;
		logic [3:0]  out_b_amplitude;
		logic [3:0]  out_a_amplitude;
		logic        sync_power_down;
		logic        ref_detector_power_down;
		logic        temp_adc_power_down;
	} sds_ctrl_t;

	// Codes 00..11 map to divide by 1, 2, 4, 8
	function automatic logic [3:0] sds_div_ratio(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

endpackage

// >>> hw/sds_clk_div.sv
// Purpose: Divided clock as a one-cycle enable pulse every 1, 2, 4 or 8
//          cycles.
// Assumes: Ratio comes from registered control.
// Notes:   A ratio change takes effect at once, compared with the running count.
`timescale 1ns/1ps
module sds_clk_div (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] ratio_i,
	output logic            tick_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} sds_div_st_t;

	sds_div_st_t s_q;
	sds_div_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (s_q.cnt >= ratio_i - 4'h1) begin
			s_d.cnt  = 4'h0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt  = s_q.cnt + 4'h1;
			s_d.tick = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;
endmodule

// >>> hw/sds_resync_timer.sv
// Purpose: Waits the programmed count after a start event, then pulses.
// Assumes: Start is a one-cycle pulse on mclk_i.
// Notes:   Dropping the enable abandons a wait in progress.
`timescale 1ns/1ps
module sds_resync_timer (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        enable_i,
	input  wire logic        start_i,
	input  wire logic [15:0] wait_i,
	output logic             busy_o,
	output logic             apply_o
);
	typedef struct packed {
		logic        busy;
		logic [15:0] cnt;
		logic        fire;
	} sds_tmr_st_t;

	sds_tmr_st_t s_q;
	sds_tmr_st_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.fire = 1'b0;
		if (!enable_i) begin
			s_d.busy = 1'b0;
		end else if (start_i) begin
			s_d.busy = 1'b1;
			s_d.cnt  = wait_i;
		end else if (s_q.busy) begin
			if (s_q.cnt == 16'h0000) begin
				s_d.busy = 1'b0;
				s_d.fire = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy_o  = s_q.busy;
	assign apply_o = s_q.fire;
endmodule

// >>> hw/sds_regs.sv
// Purpose: Divider, resync, modulator, amplitude and power control bank
//          behind the serial register port.
// Assumes: SPI pins are asynchronous to mclk_i and much slower than it.
// Notes:   Mode 0 SPI: data in on rising sclk, data out on falling sclk.
`timescale 1ns/1ps
module sds_regs (
	input  wire logic         mclk_i,
	input  wire logic         nrst_i,
	input  wire logic         sclk_i,
	input  wire logic         cs_n_i,
	input  wire logic         sdi_i,
	output logic              sdo_o,
	output logic              sdo_oe_o,
	input  wire logic         sync_pin_i,
	input  wire logic         cal_done_i,
	input  wire logic         resync_enable_i,
	input  wire logic         ref_div_duty_high_i,
	output sds_pkg::sds_ctrl_t ctrl_o,
	output logic              ref_div_tick_o,
	output logic              fb_div_tick_o,
	output logic              resync_busy_o,
	output logic              resync_apply_o
);
	typedef struct packed {
		logic [1:0]           sclk_s;
		logic [1:0]           csn_s;
		logic [1:0]           sdi_s;
		logic [1:0]           sync_s;
		logic                 sclk_d;
		logic                 sync_d;
		sds_pkg::sds_spi_st_t st;
		logic [4:0]           bitcnt;
		logic [15:0]          cmd;
		logic [7:0]           wdata;
		logic [7:0]           rdata;
		logic                 sdo;
		logic                 sdo_oe;
		sds_pkg::sds_regs_t   regs;
		sds_pkg::sds_ctrl_t   ctrl;
		logic                 first;
	} sds_state_t;

	sds_state_t s_q;
	sds_state_t s_d;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       sync_rise;
	logic       resync_start;
	logic       is_read;
	logic [14:0] addr;

	// Unmapped addresses read as zero and ignore writes
	function automatic logic [7:0] reg_read(
		input sds_pkg::sds_regs_t r,
		input logic [14:0]        a
	);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			sds_pkg::ADDR_REF_CTRL: v = r.ref_ctrl;
			sds_pkg::ADDR_WAIT_LO:  v = r.wait_lo;
			sds_pkg::ADDR_WAIT_HI:  v = r.wait_hi;
			sds_pkg::ADDR_SPARE:    v = r.spare;
			sds_pkg::ADDR_MOD_CTRL: v = r.mod_ctrl;
			sds_pkg::ADDR_AMP:      v = r.amp;
			sds_pkg::ADDR_AUX_PD:   v = r.aux_pd;
			default:                v = 8'h00;
		endcase
		return v;
	endfunction

	// Edge detectors look only at the second synchroniser stage
	assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_d;
	assign sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_d;
	assign sync_rise = s_q.sync_s[1] & ~s_q.sync_d;
	assign is_read   = s_q.cmd[sds_pkg::B_RD_FLAG];
	assign addr      = s_q.cmd[14:0];

	// Selector high: calibration done starts the wait, else the sync pin
	assign resync_start = s_q.ctrl.resync_reset_select ? cal_done_i
		: sync_rise;

	always_comb begin
		s_d        = s_q;
		s_d.sclk_s = {s_q.sclk_s[0], sclk_i};
		s_d.csn_s  = {s_q.csn_s[0], cs_n_i};
		s_d.sdi_s  = {s_q.sdi_s[0], sdi_i};
		s_d.sync_s = {s_q.sync_s[0], sync_pin_i};
		s_d.sclk_d = s_q.sclk_s[1];
		s_d.sync_d = s_q.sync_s[1];
		s_d.first  = 1'b0;

		if (s_q.csn_s[1]) begin
			s_d.st     = sds_pkg::SDS_IDLE;
			s_d.bitcnt = 5'h00;
			s_d.sdo_oe = 1'b0;
		end else begin
			case (s_q.st)
				sds_pkg::SDS_IDLE: begin
					s_d.st     = sds_pkg::SDS_CMD;
					s_d.bitcnt = 5'h00;
				end
				sds_pkg::SDS_CMD: begin
					if (sclk_rise) begin
						s_d.cmd    = {s_q.cmd[14:0], s_q.sdi_s[1]};
						s_d.bitcnt = s_q.bitcnt + 5'h01;
						if (s_q.bitcnt == sds_pkg::LAST_CMD_BIT) begin
							s_d.st     = sds_pkg::SDS_DATA;
							s_d.rdata  = reg_read(s_q.regs,
								s_d.cmd[14:0]);
							s_d.sdo_oe = s_d.cmd[sds_pkg::B_RD_FLAG];
						end
					end
				end
				sds_pkg::SDS_DATA: begin
					if (sclk_fall) begin
						s_d.sdo   = s_q.rdata[7];
						s_d.rdata = {s_q.rdata[6:0], 1'b0};
					end
					if (sclk_rise) begin
						s_d.wdata  = {s_q.wdata[6:0], s_q.sdi_s[1]};
						s_d.bitcnt = s_q.bitcnt + 5'h01;
						if (s_q.bitcnt == sds_pkg::LAST_DATA_BIT) begin
							s_d.st = sds_pkg::SDS_DONE;
						end
					end
				end
				sds_pkg::SDS_DONE: begin
					// Commit once per frame; further clocks are ignored
					s_d.sdo_oe = 1'b0;
					if (!is_read && s_q.bitcnt != 5'h00) begin
						s_d.bitcnt = 5'h00;
						case (addr)
							sds_pkg::ADDR_REF_CTRL:
								s_d.regs.ref_ctrl = s_q.wdata;
							sds_pkg::ADDR_WAIT_LO:
								s_d.regs.wait_lo = s_q.wdata;
							sds_pkg::ADDR_WAIT_HI:
								s_d.regs.wait_hi = s_q.wdata;
							sds_pkg::ADDR_SPARE:
								s_d.regs.spare = s_q.wdata;
							sds_pkg::ADDR_MOD_CTRL:
								s_d.regs.mod_ctrl = s_q.wdata;
							sds_pkg::ADDR_AMP:
								s_d.regs.amp = s_q.wdata;
							sds_pkg::ADDR_AUX_PD:
								s_d.regs.aux_pd = s_q.wdata;
							default: begin
							end
						endcase
					end
				end
				default: s_d.st = sds_pkg::SDS_IDLE;
			endcase
		end

		// Registered control view of the bank
		s_d.ctrl.ref_retime_edge_sel =
			s_q.regs.ref_ctrl[sds_pkg::B_EDGE];
		case (s_q.regs.ref_ctrl[sds_pkg::B_POL_HI:sds_pkg::B_POL_LO])
			sds_pkg::POL_NEVER:   s_d.ctrl.ref_invert = 1'b0;
			sds_pkg::POL_ALWAYS:  s_d.ctrl.ref_invert = 1'b1;
			// Invert only when it brings the high time to the wanted side
			sds_pkg::POL_HI_DUTY:
				s_d.ctrl.ref_invert = ~ref_div_duty_high_i;
			sds_pkg::POL_LO_DUTY:
				s_d.ctrl.ref_invert = ref_div_duty_high_i;
			default: s_d.ctrl.ref_invert = 1'b0;
		endcase
		s_d.ctrl.ref_div1_ratio = sds_pkg::sds_div_ratio(
			s_q.regs.ref_ctrl[sds_pkg::B_SH_HI:sds_pkg::B_SH_LO]);
		if (s_q.regs.ref_ctrl[sds_pkg::B_FB_SEL]) begin
			s_d.ctrl.fb_div1_ratio = sds_pkg::sds_div_ratio(
				s_q.regs.ref_ctrl[sds_pkg::B_FB_HI:sds_pkg::B_FB_LO]);
		end else begin
			s_d.ctrl.fb_div1_ratio = sds_pkg::sds_div_ratio(
				s_q.regs.ref_ctrl[sds_pkg::B_SH_HI:sds_pkg::B_SH_LO]);
		end
		s_d.ctrl.resync_wait = {s_q.regs.wait_hi, s_q.regs.wait_lo};
		s_d.ctrl.resync_reset_select =
			s_q.regs.mod_ctrl[sds_pkg::B_RS_SEL];
		s_d.ctrl.modulator_lsb_plus_one =
			s_q.regs.mod_ctrl[sds_pkg::B_MODULATOR_LSB_PLUS_ONE];
		s_d.ctrl.aux_mod_enable = s_q.regs.mod_ctrl[sds_pkg::B_AUX_MOD];
		s_d.ctrl.first_dither_position =
			s_q.regs.mod_ctrl[sds_pkg::B_DIT_HI:sds_pkg::B_DIT_LO];
		s_d.ctrl.second_acc_dither_enable =
			s_q.regs.mod_ctrl[sds_pkg::B_DIT2];
		s_d.ctrl.first_acc_dither_enable =
			s_q.regs.mod_ctrl[sds_pkg::B_DIT1];
		s_d.ctrl.out_b_amplitude =
			s_q.regs.amp[sds_pkg::B_AMPB_HI:sds_pkg::B_AMPB_LO];
		s_d.ctrl.out_a_amplitude =
			s_q.regs.amp[sds_pkg::B_AMPA_HI:sds_pkg::B_AMPA_LO];
		s_d.ctrl.sync_power_down =
			s_q.regs.aux_pd[sds_pkg::B_SYNC_POWER_DOWN];
		s_d.ctrl.ref_detector_power_down =
			s_q.regs.aux_pd[sds_pkg::B_REF_DETECTOR_POWER_DOWN];
		s_d.ctrl.temp_adc_power_down =
			s_q.regs.aux_pd[sds_pkg::B_TEMP_ADC_POWER_DOWN];
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q                              <= '0;
			s_q.csn_s                        <= 2'h3;
			s_q.regs.aux_pd                  <= sds_pkg::RST_AUX_PD;
			s_q.ctrl.ref_div1_ratio          <= 4'h1;
			s_q.ctrl.fb_div1_ratio           <= 4'h1;
			s_q.ctrl.ref_detector_power_down <= 1'b1;
			s_q.first                        <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign sdo_o    = s_q.sdo;
	assign sdo_oe_o = s_q.sdo_oe;
	assign ctrl_o   = s_q.ctrl;

	sds_clk_div u_ref_div (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.ratio_i (s_q.ctrl.ref_div1_ratio),
		.tick_o  (ref_div_tick_o)
	);

	sds_clk_div u_fb_div (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.ratio_i (s_q.ctrl.fb_div1_ratio),
		.tick_o  (fb_div_tick_o)
	);

	// Timer holds off unless resync mode is on
	sds_resync_timer u_resync (
		.mclk_i   (mclk_i),
		.nrst_i   (nrst_i),
		.enable_i (resync_enable_i),
		.start_i  (resync_start),
		.wait_i   (s_q.ctrl.resync_wait),
		.busy_o   (resync_busy_o),
		.apply_o  (resync_apply_o)
	);

	// Control view lags the bank by one cycle, so checks look one back

	AST_EDGE_SEL: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 ctrl_o.ref_retime_edge_sel ==
		$past(s_q.regs.ref_ctrl[sds_pkg::B_EDGE]))
		else $error("retime edge select does not follow register");

	AST_POL_FIXED: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(s_q.regs.ref_ctrl[sds_pkg::B_POL_HI:sds_pkg::B_POL_LO] ==
		sds_pkg::POL_NEVER) |=> !ctrl_o.ref_invert)
		else $error("never-invert code inverted");

	AST_POL_ALWAYS: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(s_q.regs.ref_ctrl[sds_pkg::B_POL_HI:sds_pkg::B_POL_LO] ==
		sds_pkg::POL_ALWAYS) |=> ctrl_o.ref_invert)
		else $error("always-invert code did not invert");

	AST_POL_AUTO: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(s_q.regs.ref_ctrl[sds_pkg::B_POL_HI:sds_pkg::B_POL_LO] ==
		sds_pkg::POL_HI_DUTY) |=>
		ctrl_o.ref_invert == !$past(ref_div_duty_high_i))
		else $error("high duty mode chose wrong polarity");

	AST_POL_AUTO_LO: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(s_q.regs.ref_ctrl[sds_pkg::B_POL_HI:sds_pkg::B_POL_LO] ==
		sds_pkg::POL_LO_DUTY) |=>
		ctrl_o.ref_invert == $past(ref_div_duty_high_i))
		else $error("low duty mode chose wrong polarity");

	AST_FB_SHARED: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		!s_q.regs.ref_ctrl[sds_pkg::B_FB_SEL] |=>
		ctrl_o.fb_div1_ratio == ctrl_o.ref_div1_ratio)
		else $error("feedback divider not shared");

	AST_FB_DED: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		s_q.regs.ref_ctrl[sds_pkg::B_FB_SEL] |=>
		ctrl_o.fb_div1_ratio == (4'h1 <<
		$past(s_q.regs.ref_ctrl[sds_pkg::B_FB_HI:sds_pkg::B_FB_LO])))
		else $error("dedicated feedback divider not applied");

	AST_REF_RATIO: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 ctrl_o.ref_div1_ratio == (4'h1 <<
		$past(s_q.regs.ref_ctrl[sds_pkg::B_SH_HI:sds_pkg::B_SH_LO])))
		else $error("shared divider code not applied");

	AST_WAIT: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 ctrl_o.resync_wait ==
		{$past(s_q.regs.wait_hi), $past(s_q.regs.wait_lo)})
		else $error("resync wait not formed from both bytes");

	AST_APPLY_ONCE: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		resync_apply_o |=> !resync_apply_o)
		else $error("resync apply lasted more than one cycle");

	AST_RESYNC_SRC: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(resync_enable_i && ctrl_o.resync_reset_select && cal_done_i)
		##1 resync_enable_i |-> resync_busy_o || resync_apply_o)
		else $error("calibration done did not start wait");

	AST_RESYNC_PIN: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		(resync_enable_i && !ctrl_o.resync_reset_select && sync_rise)
		##1 resync_enable_i |-> resync_busy_o || resync_apply_o)
		else $error("sync pin edge did not start wait");

	AST_MOD_VIEW: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 {ctrl_o.resync_reset_select, ctrl_o.modulator_lsb_plus_one,
		ctrl_o.aux_mod_enable, ctrl_o.first_dither_position,
		ctrl_o.second_acc_dither_enable, ctrl_o.first_acc_dither_enable}
		== $past(s_q.regs.mod_ctrl))
		else $error("modulator controls do not follow register");

	AST_AMP_VIEW: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 {ctrl_o.out_b_amplitude, ctrl_o.out_a_amplitude} ==
		$past(s_q.regs.amp))
		else $error("amplitude codes do not follow register");

	AST_RDET_PD: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 ctrl_o.ref_detector_power_down ==
		$past(s_q.regs.aux_pd[sds_pkg::B_REF_DETECTOR_POWER_DOWN]))
		else $error("reference detector power down wrong");

	AST_SYNC_ADC_PD: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		##1 {ctrl_o.sync_power_down, ctrl_o.temp_adc_power_down} ==
		{$past(s_q.regs.aux_pd[sds_pkg::B_SYNC_POWER_DOWN]),
		$past(s_q.regs.aux_pd[sds_pkg::B_TEMP_ADC_POWER_DOWN])})
		else $error("sync or temperature power down wrong");

	AST_RESET_VAL: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		s_q.first |-> s_q.regs.aux_pd == sds_pkg::RST_AUX_PD
		&& s_q.regs.ref_ctrl == sds_pkg::RST_ZERO
		&& {s_q.regs.wait_hi, s_q.regs.wait_lo} == {2{sds_pkg::RST_ZERO}}
		&& {s_q.regs.spare, s_q.regs.mod_ctrl, s_q.regs.amp} ==
		{3{sds_pkg::RST_ZERO}}
		&& ctrl_o.ref_detector_power_down
		&& !ctrl_o.sync_power_down && !ctrl_o.temp_adc_power_down)
		else $error("bank reset values wrong");

	AST_RESYNC_OFF: assert property (
		@(posedge mclk_i) disable iff (!nrst_i)
		!resync_enable_i |=> !resync_busy_o && !resync_apply_o)
		else $error("resync active while mode disabled");
endmodule

// >>> dv/sds_regs_test.sv
// Purpose: Self-checking bench for the divider, resync and power bank.
// Assumes: Mode 0 serial frames, sclk half period of six mclk cycles.
// Notes:   Expected values come from the register map, not the design.
`timescale 1ns/1ps
module sds_regs_test;
	logic               mclk_i = 1'b0;
	logic               nrst_i = 1'b0;
	logic               sclk_i = 1'b0;
	logic               cs_n_i = 1'b1;
	logic               sdi_i = 1'b0;
	logic               sync_pin_i = 1'b0;
	logic               cal_done_i = 1'b0;
	logic               resync_enable_i = 1'b0;
	logic               ref_div_duty_high_i = 1'b0;
	logic               sdo_o;
	logic               sdo_oe_o;
	sds_pkg::sds_ctrl_t ctrl_o;
	logic               ref_div_tick_o;
	logic               fb_div_tick_o;
	logic               resync_busy_o;
	logic               resync_apply_o;
	int                 n_errors = 0;
	int                 samples_checked = 0;

	always #10 mclk_i = ~mclk_i;

	sds_regs i_dut (
		.mclk_i              (mclk_i),
		.nrst_i              (nrst_i),
		.sclk_i              (sclk_i),
		.cs_n_i              (cs_n_i),
		.sdi_i               (sdi_i),
		.sdo_o               (sdo_o),
		.sdo_oe_o            (sdo_oe_o),
		.sync_pin_i          (sync_pin_i),
		.cal_done_i          (cal_done_i),
		.resync_enable_i     (resync_enable_i),
		.ref_div_duty_high_i (ref_div_duty_high_i),
		.ctrl_o              (ctrl_o),
		.ref_div_tick_o      (ref_div_tick_o),
		.fb_div_tick_o       (fb_div_tick_o),
		.resync_busy_o       (resync_busy_o),
		.resync_apply_o      (resync_apply_o)
	);

	task automatic close_out;
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic chk(input string what, input logic [15:0] e,
			input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask

	// Slow sclk keeps sdo settled at each sample despite the sync lag
	task automatic spi_frame(input logic rd_f, input logic [14:0] a,
			input logic [7:0] wd, output logic [7:0] rdat);
		logic [23:0] sh;
		sh = {rd_f, a, wd};
		rdat = 8'h00;
		@(posedge mclk_i);
		cs_n_i <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			sdi_i <= sh[23 - i];
			wait_clk(6);
			if (i >= 16)
				rdat[23 - i] = sdo_o;
			if (i == 20)
				chk_bit("sdo_oe", rd_f, sdo_oe_o);
			sclk_i <= 1'b1;
			wait_clk(6);
			sclk_i <= 1'b0;
		end
		wait_clk(8);
		cs_n_i <= 1'b1;
		wait_clk(6);
		chk_bit("sdo_oe idle", 1'b0, sdo_oe_o);
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] x;
		spi_frame(1'b0, a, d, x);
	endtask

	task automatic rd_chk(input string what, input logic [14:0] a,
			input logic [7:0] e);
		logic [7:0] x;
		spi_frame(1'b1, a, 8'h00, x);
		chk(what, {8'h00, e}, {8'h00, x});
	endtask

	// Skips past the next wrap first, as the period running at a ratio change is cut or stretched
	task automatic tick_gap(input logic fb, output logic [15:0] n);
		int k;
		n = 16'h0;
		wait_clk(20);
		for (k = 0; k < 40; k++) begin
			@(posedge mclk_i);
			if ((fb ? fb_div_tick_o : ref_div_tick_o) === 1'b1)
				break;
		end
		do begin
			@(posedge mclk_i);
			n++;
		end while ((fb ? fb_div_tick_o : ref_div_tick_o) !== 1'b1 && n < 40);
	endtask

	task automatic t_reset;
		for (int k = 0; k < 6; k++)
			rd_chk("reset", 15'h0024 + 15'(k), 8'h00);
		rd_chk("pd reset", 15'h002a, 8'h04);
		chk_bit("rdet pd", 1'b1, ctrl_o.ref_detector_power_down);
		chk_bit("sync pd", 1'b0, ctrl_o.sync_power_down);
		chk_bit("adc pd", 1'b0, ctrl_o.temp_adc_power_down);
	endtask

	task automatic t_fields(input logic [15:0] w, input logic [7:0] m,
			input logic [7:0] a, input logic [7:0] p);
		sds_pkg::sds_ctrl_t c;
		wr(15'h0025, w[7:0]);
		wr(15'h0026, w[15:8]);
		wr(15'h0028, m);
		wr(15'h0029, a);
		wr(15'h002a, p);
		c = ctrl_o;
		chk("wait", w, c.resync_wait);
		chk("mod", {8'h00, m}, {8'h00, c.resync_reset_select,
			c.modulator_lsb_plus_one, c.aux_mod_enable,
			c.first_dither_position, c.second_acc_dither_enable,
			c.first_acc_dither_enable});
		chk("amp", {8'h00, a},
			{8'h00, c.out_b_amplitude, c.out_a_amplitude});
		chk("pd", {13'h0, p[4], p[2], p[1]}, {13'h0, c.sync_power_down,
			c.ref_detector_power_down, c.temp_adc_power_down});
	endtask

	task automatic t_ref(input logic [7:0] v, input logic duty);
		logic        inv;
		logic [15:0] g;
		ref_div_duty_high_i <= duty;
		wr(15'h0024, v);
		case (v[6:5])
			2'b00: inv = 1'b0;
			2'b01: inv = 1'b1;
			2'b10: inv = ~duty;
			default: inv = duty;
		endcase
		chk_bit("edge", v[7], ctrl_o.ref_retime_edge_sel);
		chk_bit("invert", inv, ctrl_o.ref_invert);
		chk("ref ratio", 16'h1 << v[1:0], {12'h0, ctrl_o.ref_div1_ratio});
		chk("fb ratio", 16'h1 << (v[4] ? v[3:2] : v[1:0]),
			{12'h0, ctrl_o.fb_div1_ratio});
		tick_gap(1'b0, g);
		chk("ref period", 16'h1 << v[1:0], g);
		tick_gap(1'b1, g);
		chk("fb period", 16'h1 << (v[4] ? v[3:2] : v[1:0]), g);
	endtask

	// Counts from the first busy sample to the apply sample
	task automatic t_resync(input logic pin, input logic [15:0] w);
		logic [15:0] n;
		n = 16'h0;
		wr(15'h0025, w[7:0]);
		wr(15'h0026, w[15:8]);
		wr(15'h0028, {~pin, 7'h00});
		resync_enable_i <= 1'b1;
		@(posedge mclk_i);
		if (pin)
			sync_pin_i <= 1'b1;
		else
			cal_done_i <= 1'b1;
		for (int k = 0; k < 400; k++) begin
			@(posedge mclk_i);
			cal_done_i <= 1'b0;
			if (k == 4)
				sync_pin_i <= 1'b0;
			if (resync_apply_o === 1'b1)
				break;
			if (resync_busy_o === 1'b1 || n != 16'h0)
				n++;
		end
		chk("wait cycles", w + 16'h1, n);
		@(posedge mclk_i);
		chk_bit("apply width", 1'b0, resync_apply_o);
	endtask

	task automatic t_refuse;
		wr(15'h0025, 8'h00);
		wr(15'h0026, 8'h01);
		wr(15'h0028, 8'h80);
		resync_enable_i <= 1'b0;
		cal_done_i <= 1'b1;
		@(posedge mclk_i);
		cal_done_i <= 1'b0;
		wait_clk(6);
		chk_bit("busy off", 1'b0, resync_busy_o);
		resync_enable_i <= 1'b1;
		sync_pin_i <= 1'b1;
		wait_clk(6);
		sync_pin_i <= 1'b0;
		chk_bit("pin ignored", 1'b0, resync_busy_o);
		cal_done_i <= 1'b1;
		@(posedge mclk_i);
		cal_done_i <= 1'b0;
		wait_clk(10);
		chk_bit("busy on", 1'b1, resync_busy_o);
		resync_enable_i <= 1'b0;
		wait_clk(3);
		chk_bit("aborted", 1'b0, resync_busy_o);
	endtask

	// Reserved fields are written as zero only
	task automatic t_readback;
		logic [7:0] v [7];
		v = '{8'h5a, 8'hc3, 8'h81, 8'h00, 8'hb5, 8'h96, 8'h16};
		for (int k = 0; k < 7; k++)
			wr(15'h0024 + 15'(k), v[k]);
		for (int k = 0; k < 7; k++)
			rd_chk("readback", 15'h0024 + 15'(k), v[k]);
		wr(15'h0030, 8'hff);
		rd_chk("unmapped", 15'h0030, 8'h00);
	endtask

	initial begin
		wait_clk(5);
		nrst_i <= 1'b1;
		wait_clk(5);
		t_reset();
		t_fields(16'h5ac3, 8'hb5, 8'h96, 8'h12);
		t_fields(16'ha53c, 8'h4a, 8'h69, 8'h04);
		t_ref(8'h00, 1'b0);
		t_ref(8'ha7, 1'b0);
		t_ref(8'h5e, 1'b0);
		t_ref(8'h5e, 1'b1);
		t_ref(8'hf9, 1'b1);
		t_ref(8'hf9, 1'b0);
		t_resync(1'b0, 16'h0003);
		t_resync(1'b1, 16'h0102);
		t_resync(1'b1, 16'h0000);
		t_refuse();
		t_readback();
		// Reset again mid-run: the bank must drop what was written
		nrst_i <= 1'b0;
		wait_clk(5);
		nrst_i <= 1'b1;
		wait_clk(5);
		t_reset();
		close_out();
	end

	initial begin
		#1_500_000;
		n_errors++;
		close_out();
	end
endmodule
